// ### core/mvta_pkg.sv
// Shared constants and types for the multicast and VLAN table access block.
// Assumes a 32-bit APB register bus with 12-bit byte addresses.
package mvta_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_VLAN_ENTRY0 = 12'h400;
  localparam logic [ADDR_W-1:0] OFF_VLAN_ENTRY1 = 12'h404;
  localparam logic [ADDR_W-1:0] OFF_VLAN_ENTRY2 = 12'h408;
  localparam logic [ADDR_W-1:0] OFF_VLAN_INDEX = 12'h40C;
  localparam logic [ADDR_W-1:0] OFF_VLAN_CTRL = 12'h410;
  localparam logic [ADDR_W-1:0] OFF_VLAN_MODE = 12'h414;
  localparam logic [ADDR_W-1:0] OFF_TBL_CTRL = 12'h41C;
  localparam logic [ADDR_W-1:0] OFF_MC_ENTRY = 12'h424;

  // Table sizes
  localparam int VID_W = 12;
  localparam int VLAN_DEPTH = 4096;
  localparam int MC_IDX_W = 6;
  localparam int MC_ENTRIES = 48;
  localparam int MC_GROUPS = 8;
  localparam int MC_PER_GROUP = 6;

  // Field widths
  localparam int FWD_W = 3;
  localparam int MASK_W = 7;
  localparam int PRIO_W = 3;
  localparam int STI_W = 3;
  localparam int FGID_W = 7;
  localparam int MC_RSV_W = 2;

  // Field positions
  localparam int TC_GO = 0;
  localparam int TC_DIR = 1;
  localparam int TC_SEL = 2;
  localparam int TC_IDX_LSB = 8;
  localparam int MC_FWD_LSB = 0;
  localparam int MC_RSV_LSB = 30;
  localparam int VC_DIR = 0;
  localparam int VC_START = 7;
  localparam int MODE_EN = 0;
  localparam int E0_VALID = 31;
  localparam int E0_FSEL = 27;
  localparam int E0_PRIO_LSB = 24;
  localparam int E0_STI_LSB = 12;
  localparam int E0_FGID_LSB = 0;
  localparam int E12_MASK_LSB = 0;

  localparam logic DIR_READ = 1'b1;
  localparam logic SEL_MCAST = 1'b1;

  typedef struct packed {
    logic valid;
    logic fsel;
    logic [PRIO_W-1:0] prio;
    logic [STI_W-1:0] sti;
    logic [FGID_W-1:0] fgid;
    logic [MASK_W-1:0] strip;
    logic [MASK_W-1:0] member;
  } mvta_vlan_entry_t;

  typedef enum {S_IDLE, S_MC_WR, S_MC_RD, S_VL_WR, S_VL_RD} mvta_state_t;
endpackage : mvta_pkg

// ### core/mvta_mc_table.sv
// Reserved multicast forwarding table: 48 addresses sharing 8 group masks.
// Assumes the caller holds idx and wdata steady for the write cycle.
`timescale 1ns/1ns
module mvta_mc_table
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [mvta_pkg::MC_IDX_W-1:0] idx,
  input wire logic [mvta_pkg::FWD_W-1:0] wdata,
  output logic [mvta_pkg::FWD_W-1:0] rdata_q
);
  import mvta_pkg::*;
  localparam int GRP_W = $clog2(MC_GROUPS);

  logic [FWD_W-1:0] grp_q [MC_GROUPS];
  logic [GRP_W-1:0] grp;
  logic in_range;

  assign in_range = idx < MC_IDX_W'(MC_ENTRIES);
  assign grp = GRP_W'(idx / MC_IDX_W'(MC_PER_GROUP));

  // One mask per group, so every address of the group follows a write
  for (genvar g = 0; g < MC_GROUPS; g++)
  begin : g_grp
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        grp_q[g] <= '0;
      else if (we && in_range && grp == GRP_W'(g))
        grp_q[g] <= wdata;
    end
  end

  // Indices past the table read as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= '0;
    else
      rdata_q <= in_range ? grp_q[grp] : '0;
  end

  chk_group_shared: assert property (
    @(posedge pclk) disable iff (!presetn)
    we && in_range |=> grp_q[$past(grp)] == $past(wdata))
    else $error("group mask not updated by write");
endmodule : mvta_mc_table

// ### core/mvta_vlan_mem.sv
// VLAN table storage: one write port, two synchronous read ports.
// Assumes the contents are loaded by software before lookups are enabled.
`timescale 1ns/1ns
module mvta_vlan_mem #(
  parameter int DEPTH = mvta_pkg::VLAN_DEPTH,
  parameter int AW = mvta_pkg::VID_W
)
(
  input wire logic pclk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire mvta_pkg::mvta_vlan_entry_t wdata,
  input wire logic [AW-1:0] raddr_a,
  output mvta_pkg::mvta_vlan_entry_t rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output mvta_pkg::mvta_vlan_entry_t rdata_b
);
  import mvta_pkg::*;

  // No reset on purpose: a cleared 4k array costs 4k cycles or a huge reset tree
  mvta_vlan_entry_t mem [DEPTH];

  always_ff @(posedge pclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge pclk)
  begin
    rdata_a <= mem[raddr_a];
    rdata_b <= mem[raddr_b];
  end
endmodule : mvta_vlan_mem

// ### core/mvta_table_access.sv
// Register bank for indirect access to the reserved multicast and VLAN tables,
// plus the per-packet VLAN lookup port. Assumes an APB master on pclk.
// Function
// - Direction bit 1 requests a read of the selected entry.
// - Software sets go_done_flag; hardware clears it when the access is done.
// - A finished multicast read loads the entry into the multicast data register.
// - Multicast data bits 2..0 forward to ports 3..1 when set.
// - With VLAN mode on, every ingress lookup reads the VLAN table.
// - The VLAN table has 4096 entries, reached one at a time indirectly.
// - Each VLAN entry has a valid flag; 1 makes it usable.
// - membership_forward_select 1 forwards by member_port_mask, else alternative rules.
// - Each VLAN entry carries a 3-bit priority.
// - Each VLAN entry carries a 3-bit spanning_tree_instance.
// - Each VLAN entry carries a 7-bit filter_group_id for address hashing.
// - Each entry has a 7-bit egress_tag_strip_mask, port 1 at bit 0.
// - Each entry has a 7-bit member_port_mask, port 1 at bit 0.
// - Start bit 7 launches the VLAN access and clears itself when done.
// - Multicast write: load forward mask, then control with direction 0.
// - Writing one multicast address changes its whole group of the 48.
// - A VLAN read presents the entry in the three entry registers.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
module mvta_table_access
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [mvta_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mvta_pkg::DATA_W-1:0] pwdata,
  output logic [mvta_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic lookup_req,
  input wire logic [mvta_pkg::VID_W-1:0] lookup_vid,
  output logic lookup_done,
  output logic lookup_hit,
  output logic lookup_use_member,
  output logic [mvta_pkg::FWD_W-1:0] lookup_member_mask,
  output logic [mvta_pkg::FWD_W-1:0] lookup_strip_mask,
  output logic [mvta_pkg::PRIO_W-1:0] lookup_priority,
  output logic [mvta_pkg::STI_W-1:0] lookup_sti,
  output logic [mvta_pkg::FGID_W-1:0] lookup_fgid,
  output logic vlan_mode_en
);
  import mvta_pkg::*;

  mvta_state_t state_q;
  logic pready_q;
  logic pslverr_q;
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] rd_word;
  logic mapped;
  logic acc_wr;

  // Shared table control
  logic go_q;
  logic dir_q;
  logic sel_q;
  logic [MC_IDX_W-1:0] idx_q;
  logic [FWD_W-1:0] fwd_q;
  logic [MC_RSV_W-1:0] mc_rsv_q;
  logic [FWD_W-1:0] mc_rdata;
  logic mc_we;
  logic mc_fin;

  // VLAN access
  mvta_vlan_entry_t stage_q;
  mvta_vlan_entry_t vl_rdata_a;
  mvta_vlan_entry_t vl_rdata_b;
  logic [VID_W-1:0] vid_q;
  logic start_q;
  logic vdir_q;
  logic vl_fin;
  logic vlan_mode_q;
  logic lk_pend_q;

  logic wr_tbl;
  logic wr_mce;
  logic wr_e0;
  logic wr_e1;
  logic wr_e2;

  // APB: zero wait states, pready is the access-phase marker
  assign acc_wr = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wr_tbl = acc_wr && paddr == OFF_TBL_CTRL;
  assign wr_mce = acc_wr && paddr == OFF_MC_ENTRY;
  assign wr_e0 = acc_wr && paddr == OFF_VLAN_ENTRY0;
  assign wr_e1 = acc_wr && paddr == OFF_VLAN_ENTRY1;
  assign wr_e2 = acc_wr && paddr == OFF_VLAN_ENTRY2;

  always_comb
  begin
    rd_word = '0;
    mapped = 1'b1;
    case (paddr)
      OFF_VLAN_ENTRY0:
      begin
        rd_word[E0_VALID] = stage_q.valid;
        rd_word[E0_FSEL] = stage_q.fsel;
        rd_word[E0_PRIO_LSB +: PRIO_W] = stage_q.prio;
        rd_word[E0_STI_LSB +: STI_W] = stage_q.sti;
        rd_word[E0_FGID_LSB +: FGID_W] = stage_q.fgid;
      end
      OFF_VLAN_ENTRY1: rd_word[E12_MASK_LSB +: MASK_W] = stage_q.strip;
      OFF_VLAN_ENTRY2: rd_word[E12_MASK_LSB +: MASK_W] = stage_q.member;
      OFF_VLAN_INDEX: rd_word[VID_W-1:0] = vid_q;
      OFF_VLAN_CTRL:
      begin
        rd_word[VC_START] = start_q;
        rd_word[VC_DIR] = vdir_q;
      end
      OFF_VLAN_MODE: rd_word[MODE_EN] = vlan_mode_q;
      OFF_TBL_CTRL:
      begin
        rd_word[TC_GO] = go_q;
        rd_word[TC_DIR] = dir_q;
        rd_word[TC_SEL] = sel_q;
        rd_word[TC_IDX_LSB +: MC_IDX_W] = idx_q;
      end
      OFF_MC_ENTRY:
      begin
        rd_word[MC_RSV_LSB +: MC_RSV_W] = mc_rsv_q;
        rd_word[MC_FWD_LSB +: FWD_W] = fwd_q;
      end
      default: mapped = 1'b0;
    endcase
  end

  // Read data is sampled in the setup cycle, so status seen is one cycle old
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= psel && !penable;
      pslverr_q <= psel && !penable && !mapped;
      if (psel && !penable)
        prdata_q <= rd_word;
    end
  end

  // Sequencer; the multicast table is served first when both are launched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= S_IDLE;
    else
    begin
      unique case (state_q)
        S_IDLE:
        begin
          if (go_q)
            state_q <= (dir_q == DIR_READ) ? S_MC_RD : S_MC_WR;
          else if (start_q)
            state_q <= (vdir_q == DIR_READ) ? S_VL_RD : S_VL_WR;
        end
        S_MC_WR: state_q <= S_IDLE;
        S_MC_RD: state_q <= S_IDLE;
        S_VL_WR: state_q <= S_IDLE;
        S_VL_RD: state_q <= S_IDLE;
      endcase
    end
  end

  assign mc_fin = state_q == S_MC_WR || state_q == S_MC_RD;
  assign vl_fin = state_q == S_VL_WR || state_q == S_VL_RD;
  // Only the reserved multicast table lives here; other selections finish idle
  assign mc_we = state_q == S_MC_WR && sel_q == SEL_MCAST;

  // Shared control: a software write on the finishing edge wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go_q <= 1'b0;
      dir_q <= 1'b0;
      sel_q <= 1'b0;
      idx_q <= '0;
    end
    else
    begin
      if (mc_fin)
        go_q <= 1'b0;
      if (wr_tbl)
      begin
        go_q <= pwdata[TC_GO];
        dir_q <= pwdata[TC_DIR];
        sel_q <= pwdata[TC_SEL];
        idx_q <= pwdata[TC_IDX_LSB +: MC_IDX_W];
      end
    end
  end

  // Multicast data register; read capture wins over a software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fwd_q <= '0;
      mc_rsv_q <= '0;
    end
    else
    begin
      if (wr_mce)
      begin
        fwd_q <= pwdata[MC_FWD_LSB +: FWD_W];
        mc_rsv_q <= pwdata[MC_RSV_LSB +: MC_RSV_W];
      end
      if (state_q == S_MC_RD && sel_q == SEL_MCAST)
        fwd_q <= mc_rdata;
    end
  end

  mvta_mc_table u_mc_table (
    .pclk(pclk),
    .presetn(presetn),
    .we(mc_we),
    .idx(idx_q),
    .wdata(fwd_q),
    .rdata_q(mc_rdata)
  );

  // VLAN control, index and mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q <= 1'b0;
      vdir_q <= 1'b0;
      vid_q <= '0;
      vlan_mode_q <= 1'b0;
    end
    else
    begin
      if (vl_fin)
        start_q <= 1'b0;
      if (acc_wr && paddr == OFF_VLAN_CTRL)
      begin
        start_q <= pwdata[VC_START];
        vdir_q <= pwdata[VC_DIR];
      end
      if (acc_wr && paddr == OFF_VLAN_INDEX)
        vid_q <= pwdata[VID_W-1:0];
      if (acc_wr && paddr == OFF_VLAN_MODE)
        vlan_mode_q <= pwdata[MODE_EN];
    end
  end

  // Staged entry fields; only software and a finished read touch them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_q <= '0;
    else
    begin
      if (wr_e0)
      begin
        stage_q.valid <= pwdata[E0_VALID];
        stage_q.fsel <= pwdata[E0_FSEL];
        stage_q.prio <= pwdata[E0_PRIO_LSB +: PRIO_W];
        stage_q.sti <= pwdata[E0_STI_LSB +: STI_W];
        stage_q.fgid <= pwdata[E0_FGID_LSB +: FGID_W];
      end
      if (wr_e1)
        stage_q.strip <= pwdata[E12_MASK_LSB +: MASK_W];
      if (wr_e2)
        stage_q.member <= pwdata[E12_MASK_LSB +: MASK_W];
      if (state_q == S_VL_RD)
        stage_q <= vl_rdata_a;
    end
  end

  mvta_vlan_mem u_vlan_mem (
    .pclk(pclk),
    .we(state_q == S_VL_WR),
    .waddr(vid_q),
    .wdata(stage_q),
    .raddr_a(vid_q),
    .rdata_a(vl_rdata_a),
    .raddr_b(lookup_vid),
    .rdata_b(vl_rdata_b)
  );

  // Lookup: two-edge pipeline, requests ignored while VLAN mode is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lk_pend_q <= 1'b0;
      lookup_done <= 1'b0;
      lookup_hit <= 1'b0;
      lookup_use_member <= 1'b0;
      lookup_member_mask <= '0;
      lookup_strip_mask <= '0;
      lookup_priority <= '0;
      lookup_sti <= '0;
      lookup_fgid <= '0;
    end
    else
    begin
      lk_pend_q <= lookup_req && vlan_mode_q;
      lookup_done <= lk_pend_q;
      if (lk_pend_q)
      begin
        lookup_hit <= vl_rdata_b.valid;
        lookup_use_member <= vl_rdata_b.fsel;
        lookup_member_mask <= vl_rdata_b.member[FWD_W-1:0];
        lookup_strip_mask <= vl_rdata_b.strip[FWD_W-1:0];
        lookup_priority <= vl_rdata_b.prio;
        lookup_sti <= vl_rdata_b.sti;
        lookup_fgid <= vl_rdata_b.fgid;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign vlan_mode_en = vlan_mode_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_lookup_issued;
    lookup_req && vlan_mode_q;
  endsequence

  sequence s_lookup_answered;
    ##1 lk_pend_q ##1 lookup_done;
  endsequence

  chk_mc_go_served: assert property ($rose(go_q) |-> ##[1:2] mc_fin)
    else $error("multicast access not started");
  chk_mc_go_clear: assert property (mc_fin && !wr_tbl |=> !go_q)
    else $error("go_done_flag not cleared");
  chk_mc_read_load: assert property (
    state_q == S_MC_RD && sel_q == SEL_MCAST |=> fwd_q == $past(mc_rdata))
    else $error("multicast read data not loaded");
  chk_mc_read_word: assert property (
    psel && !penable && paddr == OFF_MC_ENTRY
    |=> prdata_q[MC_FWD_LSB +: FWD_W] == $past(fwd_q) && prdata_q[MC_RSV_LSB-1:FWD_W] == '0)
    else $error("multicast data word wrong");
  chk_vl_start_clear: assert property (
    $rose(start_q) |-> ##[1:2] vl_fin ##1 (!start_q || $past(acc_wr)))
    else $error("VLAN start bit did not clear");
  chk_vl_read_load: assert property (
    state_q == S_VL_RD |=> stage_q == $past(vl_rdata_a))
    else $error("VLAN read entry not presented");
  chk_entry_steady: assert property (
    !wr_e0 && !wr_e1 && !wr_e2 && state_q != S_VL_RD |=> $stable(stage_q))
    else $error("entry data changed without cause");
  chk_lookup_on: assert property (s_lookup_issued |-> s_lookup_answered)
    else $error("lookup not answered");
  chk_lookup_off: assert property (!vlan_mode_q |-> ##2 !lookup_done)
    else $error("lookup answered with VLAN mode off");
  chk_lookup_valid: assert property (
    lk_pend_q |=> lookup_hit == $past(vl_rdata_b.valid) && lookup_use_member == $past(vl_rdata_b.fsel))
    else $error("lookup flags do not match entry");
endmodule : mvta_table_access

// ### test/mvta_table_access_bench.sv
// Self-checking bench for the multicast and VLAN table access register bank.
// Assumes the design answers APB with one access cycle and flags clear within a few cycles.
`timescale 1ns/1ns
module mvta_table_access_bench;
  import mvta_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, lookup_req;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic pready, pslverr, lookup_done, lookup_hit, lookup_use_member, vlan_mode_en, serr;
  logic [VID_W-1:0] lookup_vid;
  logic [FWD_W-1:0] lookup_member_mask, lookup_strip_mask;
  logic [PRIO_W-1:0] lookup_priority;
  logic [STI_W-1:0] lookup_sti;
  logic [FGID_W-1:0] lookup_fgid;
  logic [31:0] d0 [4], d1 [4], d2 [4], m;
  logic [VID_W-1:0] vid [4];
  logic [FWD_W-1:0] grp [8];
  int err_total, n_tests, idx;
  localparam logic [31:0] E0_MASK = 32'h8F00707F;

  mvta_table_access i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lookup_req(lookup_req), .lookup_vid(lookup_vid), .lookup_done(lookup_done), .lookup_hit(lookup_hit),
    .lookup_use_member(lookup_use_member), .lookup_member_mask(lookup_member_mask),
    .lookup_strip_mask(lookup_strip_mask), .lookup_priority(lookup_priority), .lookup_sti(lookup_sti),
    .lookup_fgid(lookup_fgid), .vlan_mode_en(vlan_mode_en));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen, then idles one cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      chk(32'h0, 32'h1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Bounded wait for a self-clearing start bit
  task automatic poll(input logic [11:0] a, input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, a, 32'h0);
      n++;
    end while (rd[b] !== 1'b0 && n < 10);
    chk({31'h0, rd[b]}, 32'h0);
  endtask : poll

  function automatic logic [31:0] exp_lk(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    return {11'h0, a[31], a[27], a[26:24], a[14:12], a[6:0], b[2:0], c[2:0]};
  endfunction : exp_lk

  task automatic lookup(input logic [11:0] v, input logic [31:0] exp, input logic done_exp);
    lookup_req <= 1'b1;
    lookup_vid <= v;
    @(posedge pclk);
    lookup_req <= 1'b0;
    @(posedge pclk);
    #1;
    chk({31'h0, lookup_done}, {31'h0, done_exp});
    if (done_exp)
      chk({11'h0, lookup_hit, lookup_use_member, lookup_priority, lookup_sti, lookup_fgid,
        lookup_strip_mask, lookup_member_mask}, exp);
    @(posedge pclk);
  endtask : lookup

  initial
  begin
    #(50 * 20000);
    err_total++;
    conclude();
  end

  initial
  begin
    err_total = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lookup_req = 1'b0;
    lookup_vid = 12'h000;
    void'($urandom(32'h84bb));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_MC_ENTRY, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFF_VLAN_MODE, 32'h0);
    chk(rd & 32'h1, 32'h0);
    apb(1'b0, 12'h418, 32'h0);
    chk({31'h0, serr}, 32'h1);
    chk(rd, 32'h0);
    m = $urandom();
    apb(1'b1, OFF_MC_ENTRY, m);
    apb(1'b0, OFF_MC_ENTRY, 32'h0);
    chk(rd, {m[31:30], 27'h0, m[2:0]});
    // Every group written once, then read back through a randomly chosen member (member 5 for group 0)
    for (int g = 0; g < 8; g++)
    begin
      grp[g] = FWD_W'($urandom());
      idx = g * 6 + int'($urandom_range(5, 0));
      apb(1'b1, OFF_MC_ENTRY, {29'h0, grp[g]});
      apb(1'b1, OFF_TBL_CTRL, {18'h0, 6'(idx), 8'h05});
      poll(OFF_TBL_CTRL, TC_GO);
    end
    for (int g = 0; g < 8; g++)
    begin
      idx = g * 6 + ((g == 0) ? 5 : int'($urandom_range(5, 0)));
      apb(1'b1, OFF_MC_ENTRY, 32'h0);
      apb(1'b1, OFF_TBL_CTRL, {18'h0, 6'(idx), 8'h07});
      poll(OFF_TBL_CTRL, TC_GO);
      apb(1'b0, OFF_MC_ENTRY, 32'h0);
      chk(rd & 32'h7, {29'h0, grp[g]});
    end
    apb(1'b1, OFF_MC_ENTRY, 32'h5);
    apb(1'b1, OFF_TBL_CTRL, {18'h0, 6'd48, 8'h07});
    poll(OFF_TBL_CTRL, TC_GO);
    apb(1'b0, OFF_MC_ENTRY, 32'h0);
    chk(rd & 32'h7, 32'h0);
    // Static table chosen: flag still clears, multicast data untouched
    apb(1'b1, OFF_MC_ENTRY, 32'h3);
    apb(1'b1, OFF_TBL_CTRL, {18'h0, 6'd1, 8'h03});
    poll(OFF_TBL_CTRL, TC_GO);
    apb(1'b0, OFF_MC_ENTRY, 32'h0);
    chk(rd & 32'h7, 32'h3);
    // Four VLAN entries including both ends of the index range
    for (int i = 0; i < 4; i++)
    begin
      vid[i] = (i == 0) ? 12'h000 : (i == 3) ? 12'hFFF : {10'($urandom_range(1023, 1)), 2'(i)};
      d0[i] = $urandom();
      d1[i] = $urandom();
      d2[i] = $urandom();
      apb(1'b1, OFF_VLAN_ENTRY0, d0[i]);
      apb(1'b1, OFF_VLAN_ENTRY1, d1[i]);
      apb(1'b1, OFF_VLAN_ENTRY2, d2[i]);
      apb(1'b1, OFF_VLAN_INDEX, {20'h0, vid[i]});
      apb(1'b1, OFF_VLAN_CTRL, 32'h80);
      poll(OFF_VLAN_CTRL, VC_START);
      apb(1'b0, OFF_VLAN_ENTRY0, 32'h0);
      chk(rd & E0_MASK, d0[i] & E0_MASK);
    end
    for (int i = 3; i >= 0; i--)
    begin
      apb(1'b1, OFF_VLAN_ENTRY0, ~d0[i]);
      apb(1'b1, OFF_VLAN_ENTRY1, ~d1[i]);
      apb(1'b1, OFF_VLAN_ENTRY2, ~d2[i]);
      apb(1'b1, OFF_VLAN_INDEX, {20'h0, vid[i]});
      apb(1'b1, OFF_VLAN_CTRL, 32'h81);
      poll(OFF_VLAN_CTRL, VC_START);
      apb(1'b0, OFF_VLAN_ENTRY0, 32'h0);
      chk(rd & E0_MASK, d0[i] & E0_MASK);
      apb(1'b0, OFF_VLAN_ENTRY1, 32'h0);
      chk(rd & 32'h7F, d1[i] & 32'h7F);
      apb(1'b0, OFF_VLAN_ENTRY2, 32'h0);
      chk(rd & 32'h7F, d2[i] & 32'h7F);
    end
    // Lookups only once the table is programmed
    lookup(vid[1], 32'h0, 1'b0);
    apb(1'b1, OFF_VLAN_MODE, 32'h1);
    chk({31'h0, vlan_mode_en}, 32'h1);
    for (int i = 0; i < 4; i++)
      lookup(vid[i], exp_lk(d0[i], d1[i], d2[i]), 1'b1);
    apb(1'b1, OFF_VLAN_MODE, 32'h0);
    lookup(vid[2], 32'h0, 1'b0);
    conclude();
  end
endmodule : mvta_table_access_bench
